// ---- design/cthpm_top.sv ----
// cthpm_top: transmit request handling, retry control and acceptance filter
// Function
// - activity field reads receiver code while receiving; idle code when idle
// - pending request plus dominant third intermission bit starts arbitration next bit
// - add-request write scans pending buffers, loads best message, then requests
// - shift register holds id, format, dlc before arbitration, in every window
// - transmit event records the identifier actually sent on the bus
// - with retry on, lost or disturbed frames resend with correct fields
// - receive new flags set at last end-of-frame bit for accepted frames
// - init bit halts, drops frame silently; rejoin after 11 recessive bits
// - with no-retry bit set, failed frames are not retried
// - no-retry failure clears pending and sets cancel of the same buffer
// - standard element configs 100, 101, 110 flag priority and set the flag
// - extended element configs 100, 101, 110 flag priority and set the flag
// - frames accepted only by global non-match never set the priority flag
// - global non-match fields 00 or 01 accept such frames
// - extended configs 001 and 010 store into fifo 0 and fifo 1
// - extended type 10 is classic: first id value, second id mask
// - classic mask of zero makes every extended frame match
// - dominant third intermission bit counts as own start of frame
// assumes: APB master on SYS_CLK; protocol side gives one sample pulse per bit
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ns
`include "cthpm_map.svh"
module cthpm_top #(
	parameter int NBUF = 8
) (
	input  wire logic        SYS_CLK,
	input  wire logic        RST,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        PC_SAMPLE,
	input  wire logic        PC_BUS_DOM,
	input  wire logic        PC_FRAME_END,
	input  wire logic        PC_RX_XTD,
	input  wire logic [28:0] PC_RX_ID,
	input  wire logic        PC_TX_OK,
	input  wire logic        PC_TX_FAIL,
	output logic             PC_HALT,
	output logic             PC_TX_REQ,
	output logic             PC_TX_SOF_RX,
	output logic             PC_TX_XTD,
	output logic      [28:0] PC_TX_ID,
	output logic      [3:0]  PC_TX_DLC,
	output logic             TXEV_PUSH,
	output logic             TXEV_XTD,
	output logic      [28:0] TXEV_ID
);
	localparam int IW = $clog2(NBUF);
	localparam int DW = 34;

	logic                 pready;
	logic [1:0]           ctrl;
	logic [3:0]           flags;
	logic [NBUF-1:0]      pending;
	logic [NBUF-1:0]      cancel;
	logic [3:0]           gfilt;
	logic [31:0]          sf0, sf1, ef0, ef1;
	logic [30:0]          txid_stage;
	cthpm_pkg::cthpm_link_t link, next_link;
	logic [3:0]           bit_cnt;
	cthpm_pkg::cthpm_scan_t scan;
	logic [IW-1:0]        idx, best_idx, active;
	logic [29:0]          best_key;
	logic [DW-1:0]        best_word;
	logic                 found, armed;
	logic                 acc, wr, rd;
	logic                 add_wr, tx_done_ok, tx_done_fail;
	logic                 rx_hit_s, rx_hit_e, rx_prio;
	cthpm_pkg::cthpm_dest_t rx_dest;
	logic [31:0]          rd_mux;
	logic                 rd_bad;

	cthpm_mem_if #(.AW(IW), .DW(DW)) mem_port ();

	cthpm_txmem #(.NBUF(NBUF), .DW(DW)) u_mem (
		.SYS_CLK (SYS_CLK),
		.port    (mem_port)
	);

	// arbitration key: lower wins; standard beats extended on equal base id
	function automatic logic [29:0] arb_key(input logic xtd, input logic [28:0] id);
		arb_key = xtd ? {id[28:18], 1'b1, id[17:0]} : {id[10:0], 1'b0, 18'h00000};
	endfunction : arb_key

	// one filter element match, standard ids passed zero extended
	function automatic logic fmatch(input logic [1:0] typ, input logic [28:0] id,
	                                input logic [28:0] f1, input logic [28:0] f2);
		case (typ)
			`CTHPM_FT_RANGE: fmatch = (id >= f1) && (id <= f2);
			`CTHPM_FT_DUAL:  fmatch = (id == f1) || (id == f2);
			`CTHPM_FT_CLASS: fmatch = ((id ^ f1) & f2) == 29'h00000000;
			default:         fmatch = 1'b0;
		endcase
	endfunction : fmatch

	function automatic logic [1:0] act_code(input cthpm_pkg::cthpm_link_t s);
		case (s)
			cthpm_pkg::LK_IDLE:  act_code = `CTHPM_ACT_IDLE;
			cthpm_pkg::LK_INTER: act_code = `CTHPM_ACT_IDLE;
			cthpm_pkg::LK_RX:    act_code = `CTHPM_ACT_RX;
			cthpm_pkg::LK_TX:    act_code = `CTHPM_ACT_TX;
			default:             act_code = `CTHPM_ACT_SYNC;
		endcase
	endfunction : act_code

	// bus strobes: one wait state; write takes effect with pready, read data is latched the cycle before
	assign acc = PSEL && PENABLE && pready;
	assign wr = acc && PWRITE;
	assign rd = PSEL && PENABLE && !pready && !PWRITE;
	assign add_wr = wr && (PADDR == `CTHPM_OFF_ADD);
	assign tx_done_ok = (link == cthpm_pkg::LK_TX) && PC_TX_OK;
	assign tx_done_fail = (link == cthpm_pkg::LK_TX) && PC_TX_FAIL && !tx_done_ok;

	// read decode; unmapped offsets answer with an error and zero data
	always_comb
	begin
		rd_mux = 32'h00000000;
		rd_bad = 1'b0;
		case (PADDR)
			`CTHPM_OFF_CTRL:   rd_mux = {30'h00000000, ctrl};
			`CTHPM_OFF_STAT:   rd_mux = {30'h00000000, act_code(link)};
			`CTHPM_OFF_FLAGS:  rd_mux = {28'h0000000, flags};
			`CTHPM_OFF_PEND:   rd_mux[NBUF-1:0] = pending;
			`CTHPM_OFF_ADD:    rd_mux = 32'h00000000;
			`CTHPM_OFF_CANCEL: rd_mux[NBUF-1:0] = cancel;
			`CTHPM_OFF_GFILT:  rd_mux = {28'h0000000, gfilt};
			`CTHPM_OFF_SF0:    rd_mux = sf0;
			`CTHPM_OFF_SF1:    rd_mux = sf1;
			`CTHPM_OFF_EF0:    rd_mux = ef0;
			`CTHPM_OFF_EF1:    rd_mux = ef1;
			`CTHPM_OFF_TXID:   rd_mux = {1'b0, txid_stage};
			`CTHPM_OFF_TXCTL:  rd_mux = 32'h00000000;
			default:           rd_bad = 1'b1;
		endcase
	end

	// apb answer path, all from flops
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			pready <= 1'b0;
			PRDATA <= 32'h00000000;
			PSLVERR <= 1'b0;
		end
		else
		begin
			pready <= PSEL && PENABLE && !pready;
			if (PSEL && PENABLE && !pready)
				PSLVERR <= rd_bad;
			else
				PSLVERR <= 1'b0;
			if (rd)
				PRDATA <= rd_bad ? 32'h00000000 : rd_mux;
		end
	end
	assign PREADY = pready;

	// plain software registers
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			ctrl <= `CTHPM_RST_CTRL;
			gfilt <= `CTHPM_RST_GFILT;
			sf0 <= 32'h00000000;
			sf1 <= 32'h00000000;
			ef0 <= 32'h00000000;
			ef1 <= 32'h00000000;
			txid_stage <= 31'h00000000;
		end
		else if (wr)
		begin
			case (PADDR)
				`CTHPM_OFF_CTRL:  ctrl <= PWDATA[1:0];
				`CTHPM_OFF_GFILT: gfilt <= PWDATA[3:0];
				`CTHPM_OFF_SF0:   sf0 <= PWDATA;
				`CTHPM_OFF_SF1:   sf1 <= PWDATA;
				`CTHPM_OFF_EF0:   ef0 <= PWDATA;
				`CTHPM_OFF_EF1:   ef1 <= PWDATA;
				`CTHPM_OFF_TXID:  txid_stage <= PWDATA[30:0];
				default:          ;
			endcase
		end
	end

	// a txctl write commits the staged id with its dlc into the store
	assign mem_port.we = wr && (PADDR == `CTHPM_OFF_TXCTL);
	assign mem_port.waddr = IW'(PWDATA[`CTHPM_TXCTL_IDX] % NBUF);
	assign mem_port.wdata = {txid_stage[`CTHPM_TXID_XTD], txid_stage[28:0],
	                         PWDATA[`CTHPM_TXCTL_DLC]};
	assign mem_port.raddr = idx;

	// link sequencing: integration, idle, receive, transmit, intermission
	always_comb
	begin
		next_link = link;
		case (link)
			cthpm_pkg::LK_INTEG:
				if (PC_SAMPLE && !PC_BUS_DOM && bit_cnt == `CTHPM_INTEG_LAST)
					next_link = cthpm_pkg::LK_IDLE;
			cthpm_pkg::LK_IDLE:
				if (armed)
					next_link = cthpm_pkg::LK_TX;
				else if (PC_SAMPLE && PC_BUS_DOM)
					next_link = cthpm_pkg::LK_RX;
			cthpm_pkg::LK_RX:
				if (PC_FRAME_END)
					next_link = cthpm_pkg::LK_INTER;
			cthpm_pkg::LK_TX:
				if (PC_TX_OK || PC_TX_FAIL)
					next_link = cthpm_pkg::LK_INTER;
			cthpm_pkg::LK_INTER:
				if (PC_SAMPLE && bit_cnt == `CTHPM_INTER_LAST)
					next_link = !PC_BUS_DOM ? cthpm_pkg::LK_IDLE :
					            armed ? cthpm_pkg::LK_TX : cthpm_pkg::LK_RX;
				else if (PC_SAMPLE && PC_BUS_DOM)
					next_link = cthpm_pkg::LK_RX;
			default:
				next_link = cthpm_pkg::LK_INTEG;
		endcase
		if (ctrl[`CTHPM_CTRL_INIT])
			next_link = cthpm_pkg::LK_INTEG;
	end

	// link state and bit counter; a dominant bit restarts integration count
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			link <= cthpm_pkg::LK_INTEG;
			bit_cnt <= 4'h0;
		end
		else
		begin
			link <= next_link;
			if (next_link != link || ctrl[`CTHPM_CTRL_INIT])
				bit_cnt <= 4'h0;
			else if (PC_SAMPLE && link == cthpm_pkg::LK_INTEG && PC_BUS_DOM)
				bit_cnt <= 4'h0;
			else if (PC_SAMPLE)
				bit_cnt <= bit_cnt + 4'h1;
		end
	end

	// priority scan; the request is armed only once the shift fields are loaded,
	// which closes the window between the second and third intermission bits
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			scan <= cthpm_pkg::SC_IDLE;
			idx <= '0;
			found <= 1'b0;
			best_idx <= '0;
			best_key <= 30'h00000000;
			best_word <= 34'h000000000;
			armed <= 1'b0;
			active <= '0;
			PC_TX_XTD <= 1'b0;
			PC_TX_ID <= 29'h00000000;
			PC_TX_DLC <= 4'h0;
		end
		else if (link == cthpm_pkg::LK_TX)
		begin
			if (tx_done_ok || tx_done_fail)
				armed <= 1'b0;
		end
		else if (add_wr && next_link != cthpm_pkg::LK_TX)
		begin
			armed <= 1'b0;
			scan <= cthpm_pkg::SC_ADDR;
			idx <= '0;
			found <= 1'b0;
		end
		else
		begin
			case (scan)
				cthpm_pkg::SC_IDLE:
					if (!armed && pending != '0 && next_link != cthpm_pkg::LK_TX)
					begin
						scan <= cthpm_pkg::SC_ADDR;
						idx <= '0;
						found <= 1'b0;
					end
				cthpm_pkg::SC_ADDR:
					scan <= cthpm_pkg::SC_DATA;
				cthpm_pkg::SC_DATA:
				begin
					if (pending[idx] &&
					    (!found || arb_key(mem_port.rdata[33], mem_port.rdata[32:4]) < best_key))
					begin
						found <= 1'b1;
						best_idx <= idx;
						best_word <= mem_port.rdata;
						best_key <= arb_key(mem_port.rdata[33], mem_port.rdata[32:4]);
					end
					idx <= idx + 1'b1;
					scan <= (idx == IW'(NBUF - 1)) ? cthpm_pkg::SC_LOAD : cthpm_pkg::SC_ADDR;
				end
				cthpm_pkg::SC_LOAD:
				begin
					scan <= cthpm_pkg::SC_IDLE;
					if (found && pending[best_idx])
					begin
						PC_TX_XTD <= best_word[33];
						PC_TX_ID <= best_word[32:4];
						PC_TX_DLC <= best_word[3:0];
						active <= best_idx;
						armed <= 1'b1;
					end
				end
				default:
					scan <= cthpm_pkg::SC_IDLE;
			endcase
		end
	end

	// request pins toward the protocol side
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			PC_TX_REQ <= 1'b0;
			PC_TX_SOF_RX <= 1'b0;
			PC_HALT <= 1'b1;
		end
		else
		begin
			PC_TX_REQ <= (next_link == cthpm_pkg::LK_TX);
			if (link != cthpm_pkg::LK_TX && next_link == cthpm_pkg::LK_TX)
				PC_TX_SOF_RX <= (link == cthpm_pkg::LK_INTER);
			PC_HALT <= ctrl[`CTHPM_CTRL_INIT];
		end
	end

	// pending and cancel bits; a set (add write for pending, no-retry failure for cancel) wins over a same-cycle clear
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			pending <= '0;
			cancel <= '0;
		end
		else
		begin
			pending <= (pending & ~(((tx_done_ok ||
			            (tx_done_fail && ctrl[`CTHPM_CTRL_NORETX])) ?
			            NBUF'(1) : NBUF'(0)) << active)) |
			           (add_wr ? PWDATA[NBUF-1:0] : '0);
			cancel <= (cancel & ~((wr && PADDR == `CTHPM_OFF_CANCEL) ?
			           PWDATA[NBUF-1:0] : '0)) |
			          (((tx_done_fail && ctrl[`CTHPM_CTRL_NORETX]) ?
			           NBUF'(1) : NBUF'(0)) << active);
		end
	end

	// event record uses the loaded shift fields, i.e. what went on the bus
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			TXEV_PUSH <= 1'b0;
			TXEV_XTD <= 1'b0;
			TXEV_ID <= 29'h00000000;
		end
		else
		begin
			TXEV_PUSH <= tx_done_ok;
			if (tx_done_ok)
			begin
				TXEV_XTD <= PC_TX_XTD;
				TXEV_ID <= PC_TX_ID;
			end
		end
	end

	// acceptance filter for the frame ending now
	always_comb
	begin
		logic [2:0] cfg;
		logic [1:0] gnm;
		cfg = PC_RX_XTD ? ef0[`CTHPM_EF_CFG] : sf0[`CTHPM_SF_CFG];
		gnm = PC_RX_XTD ? gfilt[`CTHPM_GF_EXT] : gfilt[`CTHPM_GF_STD];
		rx_hit_s = !PC_RX_XTD && sf0[`CTHPM_SF_CFG] != `CTHPM_EC_OFF &&
		           fmatch(sf0[`CTHPM_SF_TYPE], {18'h00000, PC_RX_ID[10:0]},
		                  {18'h00000, sf1[`CTHPM_SF_ID1]}, {18'h00000, sf1[`CTHPM_SF_ID2]});
		rx_hit_e = PC_RX_XTD && ef0[`CTHPM_EF_CFG] != `CTHPM_EC_OFF &&
		           fmatch(ef1[`CTHPM_EF_TYPE], PC_RX_ID,
		                  ef0[`CTHPM_EF_ID], ef1[`CTHPM_EF_ID]);
		rx_prio = 1'b0;
		rx_dest = cthpm_pkg::DS_NONE;
		if (rx_hit_s || rx_hit_e)
		begin
			case (cfg)
				`CTHPM_EC_FIFO0:  rx_dest = cthpm_pkg::DS_FIFO0;
				`CTHPM_EC_FIFO1:  rx_dest = cthpm_pkg::DS_FIFO1;
				`CTHPM_EC_REJ:    rx_dest = cthpm_pkg::DS_NONE;
				`CTHPM_EC_PRIO:   rx_prio = 1'b1;
				`CTHPM_EC_PFIFO0:
				begin
					rx_prio = 1'b1;
					rx_dest = cthpm_pkg::DS_FIFO0;
				end
				`CTHPM_EC_PFIFO1:
				begin
					rx_prio = 1'b1;
					rx_dest = cthpm_pkg::DS_FIFO1;
				end
				default:          rx_dest = cthpm_pkg::DS_RXBUF;
			endcase
		end
		else if (gnm == `CTHPM_GN_FIFO0)
			rx_dest = cthpm_pkg::DS_FIFO0;
		else if (gnm == `CTHPM_GN_FIFO1)
			rx_dest = cthpm_pkg::DS_FIFO1;
	end

	// sticky flags, write one to clear; a hardware set in the same cycle wins
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
			flags <= 4'h0;
		else
		begin
			logic [3:0] set;
			set = 4'h0;
			if (link == cthpm_pkg::LK_RX && PC_FRAME_END && !ctrl[`CTHPM_CTRL_INIT])
			begin
				set[`CTHPM_FL_HPM] = rx_prio;
				set[`CTHPM_FL_RXBUF] = (rx_dest == cthpm_pkg::DS_RXBUF);
				set[`CTHPM_FL_FIFO0] = (rx_dest == cthpm_pkg::DS_FIFO0);
				set[`CTHPM_FL_FIFO1] = (rx_dest == cthpm_pkg::DS_FIFO1);
			end
			flags <= (flags & ~((wr && PADDR == `CTHPM_OFF_FLAGS) ? PWDATA[3:0] : 4'h0)) | set;
		end
	end
endmodule : cthpm_top

// ---- design/cthpm_map.svh ----
// cthpm_map.svh: register offsets, field positions, reset values and codes
// assumes: included by bare name; holds definitions only
`ifndef CTHPM_MAP_SVH
`define CTHPM_MAP_SVH

// register byte offsets on the apb bus
`define CTHPM_OFF_CTRL   8'h00
`define CTHPM_OFF_STAT   8'h04
`define CTHPM_OFF_FLAGS  8'h08
`define CTHPM_OFF_PEND   8'h0C
`define CTHPM_OFF_ADD    8'h10
`define CTHPM_OFF_CANCEL 8'h14
`define CTHPM_OFF_GFILT  8'h18
`define CTHPM_OFF_SF0    8'h1C
`define CTHPM_OFF_SF1    8'h20
`define CTHPM_OFF_EF0    8'h24
`define CTHPM_OFF_EF1    8'h28
`define CTHPM_OFF_TXID   8'h30
`define CTHPM_OFF_TXCTL  8'h34

// field positions
`define CTHPM_CTRL_INIT   0
`define CTHPM_CTRL_NORETX 1
`define CTHPM_FL_HPM      0
`define CTHPM_FL_RXBUF    1
`define CTHPM_FL_FIFO0    2
`define CTHPM_FL_FIFO1    3
`define CTHPM_GF_STD      1:0
`define CTHPM_GF_EXT      3:2
`define CTHPM_SF_CFG      2:0
`define CTHPM_SF_TYPE     5:4
`define CTHPM_SF_ID1      10:0
`define CTHPM_SF_ID2      26:16
`define CTHPM_EF_ID       28:0
`define CTHPM_EF_CFG      31:29
`define CTHPM_EF_TYPE     31:30
`define CTHPM_TXID_XTD    30
`define CTHPM_TXCTL_DLC   3:0
`define CTHPM_TXCTL_IDX   12:8

// reset values
`define CTHPM_RST_CTRL  2'h1
`define CTHPM_RST_GFILT 4'h0

// activity codes
`define CTHPM_ACT_SYNC 2'h0
`define CTHPM_ACT_IDLE 2'h1
`define CTHPM_ACT_RX   2'h2
`define CTHPM_ACT_TX   2'h3

// bit counts: last index of 11 recessive bits, third intermission bit
`define CTHPM_INTEG_LAST 4'hA
`define CTHPM_INTER_LAST 4'h2

// filter element configuration and type codes
`define CTHPM_EC_OFF    3'h0
`define CTHPM_EC_FIFO0  3'h1
`define CTHPM_EC_FIFO1  3'h2
`define CTHPM_EC_REJ    3'h3
`define CTHPM_EC_PRIO   3'h4
`define CTHPM_EC_PFIFO0 3'h5
`define CTHPM_EC_PFIFO1 3'h6
`define CTHPM_FT_RANGE  2'h0
`define CTHPM_FT_DUAL   2'h1
`define CTHPM_FT_CLASS  2'h2
`define CTHPM_GN_FIFO0  2'h0
`define CTHPM_GN_FIFO1  2'h1

`endif

// ---- design/cthpm_pkg.sv ----
// cthpm_pkg: types shared by the transmit request and filter block
// assumes: constants come from cthpm_map.svh
package cthpm_pkg;
	typedef enum logic [2:0] {LK_INTEG, LK_IDLE, LK_RX, LK_TX, LK_INTER} cthpm_link_t;
	typedef enum logic [1:0] {SC_IDLE, SC_ADDR, SC_DATA, SC_LOAD} cthpm_scan_t;
	typedef enum logic [1:0] {DS_NONE, DS_FIFO0, DS_FIFO1, DS_RXBUF} cthpm_dest_t;
endpackage : cthpm_pkg

// ---- design/cthpm_mem_if.sv ----
// cthpm_mem_if: port bundle between the core and its transmit buffer store
// assumes: one write and one registered read port on the same clock
`timescale 1ns/1ns
interface cthpm_mem_if #(parameter int AW = 3, parameter int DW = 34);
	logic          we;
	logic [AW-1:0] waddr;
	logic [DW-1:0] wdata;
	logic [AW-1:0] raddr;
	logic [DW-1:0] rdata;
	modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
	modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : cthpm_mem_if

// ---- design/cthpm_txmem.sv ----
// cthpm_txmem: transmit buffer headers (format, identifier, dlc)
// assumes: read data is registered, so it follows the address by one edge
`timescale 1ns/1ns
module cthpm_txmem #(
	parameter int NBUF = 8,
	parameter int DW   = 34
) (
	input  wire logic   SYS_CLK,
	cthpm_mem_if.mem    port
);
	logic [DW-1:0] store [NBUF];

	// no reset on the array: software writes a header before requesting it
	always_ff @(posedge SYS_CLK)
	begin
		if (port.we)
			store[port.waddr] <= port.wdata;
	end

	// registered read for the priority scan
	always_ff @(posedge SYS_CLK)
	begin
		port.rdata <= store[port.raddr];
	end
endmodule : cthpm_txmem

// ---- design/cthpm_top_unused.sv ----
// cthpm_top_unused: intentionally empty
`timescale 1ns/1ns

// ---- verif/cthpm_chk.sv ----
// cthpm_chk: port-level checks of cthpm_top
// assumes: bound to cthpm_top; one clock domain, async active-high reset
`timescale 1ns/1ns
`include "cthpm_map.svh"
module cthpm_chk (
	input logic        SYS_CLK,
	input logic        RST,
	input logic        PSEL,
	input logic        PENABLE,
	input logic        PWRITE,
	input logic [7:0]  PADDR,
	input logic [31:0] PWDATA,
	input logic        PREADY,
	input logic        PC_SAMPLE,
	input logic        PC_BUS_DOM,
	input logic        PC_TX_OK,
	input logic        PC_TX_FAIL,
	input logic        PC_HALT,
	input logic        PC_TX_REQ,
	input logic        PC_TX_SOF_RX,
	input logic        PC_TX_XTD,
	input logic [28:0] PC_TX_ID,
	input logic [3:0]  PC_TX_DLC,
	input logic        TXEV_PUSH,
	input logic [28:0] TXEV_ID
);
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (RST);

	// one wait state: ready two edges after setup, for one cycle
	property p_rdy;
		PSEL && !PENABLE |-> ##2 PREADY;
	endproperty
	a_rdy: assert property (p_rdy) else $error("ready late");
	property p_one;
		PREADY |=> !PREADY;
	endproperty
	a_one: assert property (p_one) else $error("ready held");
	// fields loaded before the request rises
	property p_load;
		$rose(PC_TX_REQ) |-> $stable({PC_TX_XTD, PC_TX_ID, PC_TX_DLC});
	endproperty
	a_load: assert property (p_load) else $error("fields late");
	property p_hold;
		PC_TX_REQ && $past(PC_TX_REQ) |-> $stable({PC_TX_XTD, PC_TX_ID, PC_TX_DLC});
	endproperty
	a_hold: assert property (p_hold) else $error("fields moved");
	// own start of frame only from a dominant sample seen one edge before the rise
	property p_sof;
		$rose(PC_TX_SOF_RX) |-> $rose(PC_TX_REQ) && $past(PC_SAMPLE && PC_BUS_DOM);
	endproperty
	a_sof: assert property (p_sof) else $error("bad sof start");
	property p_end;
		PC_TX_REQ && (PC_TX_OK || PC_TX_FAIL) |=> !PC_TX_REQ;
	endproperty
	a_end: assert property (p_end) else $error("request kept");
	// the event entry carries the identifier that was on the bus
	property p_ev;
		TXEV_PUSH |-> $past(PC_TX_OK && PC_TX_REQ) && TXEV_ID == $past(PC_TX_ID);
	endproperty
	a_ev: assert property (p_ev) else $error("bad event");
	property p_halt;
		PSEL && PENABLE && PREADY && PWRITE && PADDR == `CTHPM_OFF_CTRL
			|=> ##1 PC_HALT == $past(PWDATA[0], 2);
	endproperty
	a_halt: assert property (p_halt) else $error("halt mismatch");
endmodule : cthpm_chk

// ---- verif/cthpm_canbus.sv ----
// cthpm_canbus: protocol side and bus stand-in, driven by bench task calls
// assumes: one sample pulse per bit, GAP+1 idle cycles between samples
`timescale 1ns/1ns
module cthpm_canbus #(
	parameter int GAP = 8
) (
	input  wire logic        clk,
	output logic             sample    = 1'h0,
	output logic             bus_dom   = 1'h0,
	output logic             frame_end = 1'h0,
	output logic             rx_xtd    = 1'h0,
	output logic      [28:0] rx_id     = 29'h0,
	output logic             tx_ok     = 1'h0,
	output logic             tx_fail   = 1'h0
);
	// level flips off the sample point so a stale value never looks valid
	task automatic bits(input int n, input logic dom);
		repeat (n)
		begin
			@(posedge clk);
			sample  <= 1'h1;
			bus_dom <= dom;
			@(posedge clk);
			sample  <= 1'h0;
			bus_dom <= ~dom;
			repeat (GAP) @(posedge clk);
		end
	endtask : bits
	// last end-of-frame bit of a received frame
	task automatic fend(input logic xtd, input logic [28:0] id);
		@(posedge clk);
		frame_end <= 1'h1;
		rx_xtd    <= xtd;
		rx_id     <= id;
		@(posedge clk);
		frame_end <= 1'h0;
		rx_id     <= ~id;
	endtask : fend
	// acknowledge or fail the own frame, promptly or after dly cycles
	task automatic answer(input logic ok, input int dly);
		repeat (dly + 1) @(posedge clk);
		tx_ok   <= ok;
		tx_fail <= ~ok;
		@(posedge clk);
		tx_ok   <= 1'h0;
		tx_fail <= 1'h0;
	endtask : answer
endmodule : cthpm_canbus

// ---- verif/cthpm_tb_top.sv ----
// cthpm_tb_top: self-checking bench for cthpm_top
// assumes: cthpm_canbus plays the protocol side; buffers cut to two
`timescale 1ns/1ns
`include "cthpm_map.svh"
module cthpm_tb_top;
	localparam int NB = 2;
	logic        sys_clk = 1'h0;
	logic        rst     = 1'h1;
	logic        psel    = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite  = 1'h0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0;
	logic [31:0] prdata, r_dat;
	logic        pready, pslverr, halt, tx_req, sof_rx, tx_xtd, ev_push, ev_xtd;
	logic [28:0] tx_id, ev_id, rx_id;
	logic [3:0]  tx_dlc;
	logic        smp, dom, fe, rx_xtd, ok, fail, r_err;
	int          err_count = 0;
	int          n_checks = 0;
	int          n;

	always #25 sys_clk = ~sys_clk;

	cthpm_top #(.NBUF(NB)) DUT (
		.SYS_CLK(sys_clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .PC_SAMPLE(smp), .PC_BUS_DOM(dom), .PC_FRAME_END(fe),
		.PC_RX_XTD(rx_xtd), .PC_RX_ID(rx_id), .PC_TX_OK(ok), .PC_TX_FAIL(fail),
		.PC_HALT(halt), .PC_TX_REQ(tx_req), .PC_TX_SOF_RX(sof_rx), .PC_TX_XTD(tx_xtd),
		.PC_TX_ID(tx_id), .PC_TX_DLC(tx_dlc), .TXEV_PUSH(ev_push), .TXEV_XTD(ev_xtd),
		.TXEV_ID(ev_id));
	cthpm_canbus u_bus (.clk(sys_clk), .sample(smp), .bus_dom(dom), .frame_end(fe),
		.rx_xtd(rx_xtd), .rx_id(rx_id), .tx_ok(ok), .tx_fail(fail));

	task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string m);
		n_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD %0t %s got %0h exp %0h", $time, m, got, exp);
		end
	endtask : chk
	// one apb transfer held until ready; only the watchdog ends a hang
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel    <= 1'h1;
		penable <= 1'h0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge sys_clk);
		penable <= 1'h1;
		@(posedge sys_clk);
		while (pready !== 1'h1) @(posedge sys_clk);
		r_dat = prdata;
		r_err = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'h1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input string m);
		apb(1'h0, a, 32'h0);
		chk(r_dat, x, m);
	endtask : rd
	// commit an extended header to buffer idx
	task automatic load(input logic [4:0] idx, input logic [28:0] id, input logic [3:0] c);
		wr(`CTHPM_OFF_TXID, {3'h2, id});
		wr(`CTHPM_OFF_TXCTL, {19'h0, idx, 4'h0, c});
	endtask : load
	// recessive bits until the request rises, at most 12
	task automatic wait_tx(output int k);
		k = 0;
		while (tx_req !== 1'h1 && k < 12)
		begin
			u_bus.bits(1, 1'h0);
			k++;
		end
	endtask : wait_tx
	task automatic txf(input logic [28:0] id, input logic [3:0] c, input string m);
		chk({tx_req, tx_xtd, tx_dlc, tx_id}, {2'h3, c, id}, m);
	endtask : txf
	task automatic done(input logic [28:0] id, input int dly);
		u_bus.answer(1'h1, dly);
		@(posedge sys_clk);
		chk({ev_push, ev_xtd, ev_id}, {2'h3, id}, "ev");
	endtask : done
	task automatic t_reset;
		rd(`CTHPM_OFF_CTRL, {30'h0, `CTHPM_RST_CTRL}, "ctl");
		rd(`CTHPM_OFF_GFILT, 32'h0, "gfl");
		rd(`CTHPM_OFF_PEND, 32'h0, "pnd");
		wr(`CTHPM_OFF_PEND, 32'hFF);
		rd(`CTHPM_OFF_PEND, 32'h0, "ro");
		apb(1'h1, 8'h2C, 32'hF);
		chk(r_err, 1'h1, "err");
		wr(`CTHPM_OFF_CTRL, 32'h0);
		u_bus.bits(4, 1'h0);
		u_bus.bits(1, 1'h1);
		u_bus.bits(10, 1'h0);
		rd(`CTHPM_OFF_STAT, {30'h0, `CTHPM_ACT_SYNC}, "b10");
		u_bus.bits(1, 1'h0);
		rd(`CTHPM_OFF_STAT, {30'h0, `CTHPM_ACT_IDLE}, "b11");
	endtask : t_reset
	// two pending buffers: lower identifier goes first
	task automatic t_pair;
		load(5'h0, 29'h0123456, 4'h8);
		load(5'h1, 29'h0055AAA, 4'h3);
		wr(`CTHPM_OFF_ADD, 32'h3);
		wait_tx(n);
		txf(29'h0055AAA, 4'h3, "1st");
		rd(`CTHPM_OFF_PEND, 32'h3, "p2");
		done(29'h0055AAA, 0);
		wait_tx(n);
		txf(29'h0123456, 4'h8, "2nd");
		done(29'h0123456, 30);
		rd(`CTHPM_OFF_PEND, 32'h0, "p0");
		u_bus.bits(3, 1'h0);
	endtask : t_pair
	// request between second and third intermission bit, third bit dominant
	task automatic t_window;
		load(5'h1, 29'h1ABCDEF, 4'h5);
		u_bus.bits(3, 1'h1);
		rd(`CTHPM_OFF_STAT, {30'h0, `CTHPM_ACT_RX}, "rx");
		u_bus.fend(1'h0, 29'h200);
		u_bus.bits(2, 1'h0);
		wr(`CTHPM_OFF_ADD, 32'h2);
		repeat (2 * NB + 2) @(posedge sys_clk);
		u_bus.bits(1, 1'h1);
		chk({tx_req, sof_rx}, 2'h3, "sof");
		txf(29'h1ABCDEF, 4'h5, "win");
		rd(`CTHPM_OFF_FLAGS, 32'h4, "f0");
		wr(`CTHPM_OFF_FLAGS, 32'hF);
		u_bus.answer(1'h0, 5);
		@(posedge sys_clk);
		wait_tx(n);
		txf(29'h1ABCDEF, 4'h5, "rty");
		done(29'h1ABCDEF, 0);
		u_bus.bits(3, 1'h0);
	endtask : t_window
	task automatic t_noretx;
		wr(`CTHPM_OFF_CTRL, 32'h2);
		wr(`CTHPM_OFF_ADD, 32'h1);
		wait_tx(n);
		u_bus.answer(1'h0, 0);
		@(posedge sys_clk);
		rd(`CTHPM_OFF_PEND, 32'h0, "pcl");
		rd(`CTHPM_OFF_CANCEL, 32'h1, "cf");
		wait_tx(n);
		chk(n, 12, "nrt");
		wr(`CTHPM_OFF_CANCEL, 32'h1);
		rd(`CTHPM_OFF_CANCEL, 32'h0, "w1c");
	endtask : t_noretx
	// halt mid-frame, add the request, release and rejoin
	task automatic t_init;
		wr(`CTHPM_OFF_CTRL, 32'h0);
		u_bus.bits(3, 1'h1);
		wr(`CTHPM_OFF_CTRL, 32'h1);
		wr(`CTHPM_OFF_ADD, 32'h1);
		u_bus.fend(1'h0, 29'h300);
		rd(`CTHPM_OFF_FLAGS, 32'h0, "drp");
		chk(halt, 1'h1, "hlt");
		wr(`CTHPM_OFF_CTRL, 32'h0);
		wait_tx(n);
		chk(n, 11, "rej");
		done(29'h0123456, 0);
		u_bus.bits(3, 1'h0);
	endtask : t_init
	task automatic filt(input logic [5:0] s, input logic [2:0] c, input logic [3:0] g,
		input logic x, input logic [28:0] id, input logic [3:0] f);
		wr(`CTHPM_OFF_SF0, {26'h0, s});
		wr(`CTHPM_OFF_EF0, {c, 29'h0});
		wr(`CTHPM_OFF_GFILT, {28'h0, g});
		u_bus.bits(3, 1'h1);
		u_bus.fend(x, id);
		u_bus.bits(3, 1'h0);
		rd(`CTHPM_OFF_FLAGS, {28'h0, f}, "fl");
		wr(`CTHPM_OFF_FLAGS, 32'hF);
	endtask : filt
	// std element classic 0x100/0x7FF; ext element classic with zero mask
	task automatic t_filt;
		wr(`CTHPM_OFF_SF1, 32'h07FF0100);
		wr(`CTHPM_OFF_EF1, 32'h80000000);
		filt(6'h24, 3'h0, 4'h0, 1'h0, 29'h100, 4'h1);
		filt(6'h25, 3'h0, 4'h0, 1'h0, 29'h100, 4'h5);
		filt(6'h26, 3'h0, 4'h0, 1'h0, 29'h100, 4'h9);
		filt(6'h24, 3'h0, 4'h0, 1'h1, 29'h1ABCDEF, 4'h4);
		filt(6'h24, 3'h0, 4'h4, 1'h1, 29'h1ABCDEF, 4'h8);
		filt(6'h24, 3'h0, 4'h1, 1'h0, 29'h055, 4'h8);
		filt(6'h0, 3'h4, 4'h0, 1'h1, 29'h1234567, 4'h1);
		filt(6'h0, 3'h5, 4'h0, 1'h1, 29'h1234567, 4'h5);
		filt(6'h0, 3'h6, 4'h0, 1'h1, 29'h1234567, 4'h9);
		filt(6'h0, 3'h6, 4'h0, 1'h0, 29'h055, 4'h4);
		filt(6'h0, 3'h1, 4'h0, 1'h1, 29'h0000001, 4'h4);
		filt(6'h0, 3'h2, 4'h0, 1'h1, 29'h1FFFFFFF, 4'h8);
		filt(6'h0, 3'h7, 4'h0, 1'h1, 29'h00ABCDE, 4'h2);
	endtask : t_filt
	task automatic print_verdict;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : print_verdict
	// main sequence after six reset cycles
	initial
	begin
		repeat (6) @(posedge sys_clk);
		rst <= 1'h0;
		t_reset;
		t_pair;
		t_window;
		t_noretx;
		t_init;
		t_filt;
		print_verdict;
	end
	// watchdog
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		err_count++;
		print_verdict;
	end
endmodule : cthpm_tb_top

bind cthpm_top cthpm_chk u_chk (
	.SYS_CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PREADY, .PC_SAMPLE,
	.PC_BUS_DOM, .PC_TX_OK, .PC_TX_FAIL, .PC_HALT, .PC_TX_REQ, .PC_TX_SOF_RX,
	.PC_TX_XTD, .PC_TX_ID, .PC_TX_DLC, .TXEV_PUSH, .TXEV_ID);
